/* File: verilog/control_pin_gpio_reuse.v */
// Two control registers reusing control-bus pins as general I/O.
// Assumes a plain register port on core_clk and pin levels from pads.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "gpio_reuse_defs.vh"

// Overview of operation
// RULE1 - Data-line field: 00 unused, 01 in, 10 out
// RULE2 - Data-line output level from bit five
// RULE3 - Bit four reads data-line input level
// RULE4 - Clock-line field uses same encoding
// RULE5 - Clock-line output level from bit one
// RULE6 - Bit zero reads clock-line input level
// RULE7 - Bus pins open-drain, only pull low
// RULE8 - First register acts only in SPI mode
// RULE9 - Address-select levels captured at reset, read-only
// RULE10 - Bit five enables pin three input
// RULE11 - Bit four enables pin three serial data
// RULE12 - Bit three reads pin three level
// RULE13 - Bit two enables pin two output
// RULE14 - Bit one sets pin two level
// RULE15 - Bit zero selects core clock source
// RULE16 - Second register bits valid in two-wire mode
// RULE17 - Host never writes pattern 11 in fields
// RULE18 - Pin inputs pass two-stage synchroniser
module control_pin_gpio_reuse (
  input wire core_clk,
  input wire rst,
  input wire [`ADDR_WIDTH-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire spi_select,
  input wire data_line_in,
  output wire data_line_out,
  output wire data_line_oe_n,
  input wire clock_line_in,
  output wire clock_line_out,
  output wire clock_line_oe_n,
  input wire multifunction_pin_zero_in,
  input wire multifunction_pin_one_in,
  input wire multifunction_pin_three_in,
  output wire gp_input_enable,
  output wire audio_serial_data_in_enable,
  output wire audio_serial_data_in,
  output wire multifunction_pin_two_out,
  output wire multifunction_pin_two_oe_n,
  input wire pll_divider_output,
  input wire plain_divider_output,
  output wire core_clock_input,
  output wire core_clock_select
);
  reg [7:0] ctrl_a_r;
  reg [5:0] ctrl_b_r;
  reg addr0_r;
  reg addr1_r;
  reg captured_r;
  reg [7:0] rdata_nxt;
  reg [7:0] reg_a_view;
  reg [7:0] reg_b_view;
  wire [6:0] pins_sync;
  wire sel_sync;
  wire spi_mode;
  wire twowire_mode;
  wire data_in_s;
  wire clk_in_s;
  wire multifunction_pin_zero_s;
  wire multifunction_pin_one_s;
  wire multifunction_pin_three_s;
  wire data_drive_low;
  wire clk_drive_low;

  function is_output;
    input [1:0] fn;
    begin
      is_output = (fn == `FN_GP_OUTPUT);
    end
  endfunction

  function is_input;
    input [1:0] fn;
    begin
      is_input = (fn == `FN_GP_INPUT);
    end
  endfunction

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  level_sync #(
    .WIDTH(7)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({spi_select, multifunction_pin_three_in,
               multifunction_pin_one_in, multifunction_pin_zero_in,
               clock_line_in, data_line_in, 1'b0}),
    .sync_out(pins_sync)
  ); // RULE18

  assign data_in_s = pins_sync[1];
  assign clk_in_s = pins_sync[2];
  assign multifunction_pin_zero_s = pins_sync[3];
  assign multifunction_pin_one_s = pins_sync[4];
  assign multifunction_pin_three_s = pins_sync[5];
  assign sel_sync = pins_sync[6];
  assign spi_mode = sel_sync; // RULE8
  assign twowire_mode = ~sel_sync; // RULE16

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_a_r <= `REG_RESET;
      ctrl_b_r <= 6'h00;
    end else if (reg_wr) begin
      if (reg_addr == `BUS_PIN_GPIO_CONTROL_ADDR) begin
        ctrl_a_r[`DATA_FN_HI:`DATA_FN_LO] <=
          reg_wdata[`DATA_FN_HI:`DATA_FN_LO]; // RULE1
        ctrl_a_r[`DATA_OUT_BIT] <= reg_wdata[`DATA_OUT_BIT]; // RULE2
        ctrl_a_r[`CLK_FN_HI:`CLK_FN_LO] <=
          reg_wdata[`CLK_FN_HI:`CLK_FN_LO]; // RULE4
        ctrl_a_r[`CLK_OUT_BIT] <= reg_wdata[`CLK_OUT_BIT]; // RULE5
        ctrl_a_r[`DATA_IN_BIT] <= 1'b0;
        ctrl_a_r[`CLK_IN_BIT] <= 1'b0;
      end
      if (reg_addr == `MFP_CLOCK_SELECT_ADDR) begin
        ctrl_b_r[5] <= reg_wdata[`MULTIFUNCTION_PIN_THREE_GPI_EN_BIT]; // RULE10
        ctrl_b_r[4] <= reg_wdata[`MULTIFUNCTION_PIN_THREE_SDI_EN_BIT]; // RULE11
        ctrl_b_r[2] <= reg_wdata[`MULTIFUNCTION_PIN_TWO_GPO_EN_BIT]; // RULE13
        ctrl_b_r[1] <= reg_wdata[`MULTIFUNCTION_PIN_TWO_OUT_BIT]; // RULE14
        ctrl_b_r[0] <= reg_wdata[`CLK_SRC_BIT]; // RULE15
        ctrl_b_r[3] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Address-select capture at reset release
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      captured_r <= 1'b0;
      addr0_r <= 1'b0;
      addr1_r <= 1'b0;
    end else if (!captured_r) begin
      captured_r <= 1'b1;
      addr0_r <= multifunction_pin_one_s; // RULE9
      addr1_r <= multifunction_pin_zero_s; // RULE9
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  assign data_drive_low = spi_mode & is_output(ctrl_a_r[7:6]) &
                          ~ctrl_a_r[`DATA_OUT_BIT]; // RULE8
  assign clk_drive_low = spi_mode & is_output(ctrl_a_r[3:2]) &
                         ~ctrl_a_r[`CLK_OUT_BIT]; // RULE8
  assign data_line_out = 1'b0; // RULE7
  assign data_line_oe_n = ~data_drive_low; // RULE7
  assign clock_line_out = 1'b0; // RULE7
  assign clock_line_oe_n = ~clk_drive_low; // RULE7

  assign gp_input_enable = twowire_mode & ctrl_b_r[5]; // RULE10
  assign audio_serial_data_in_enable = twowire_mode & ctrl_b_r[4]; // RULE11
  assign audio_serial_data_in = multifunction_pin_three_s & audio_serial_data_in_enable;
  assign multifunction_pin_two_out = ctrl_b_r[1]; // RULE14
  assign multifunction_pin_two_oe_n = ~(twowire_mode & ctrl_b_r[2]); // RULE13

  assign core_clock_select = ctrl_b_r[0]; // RULE15
  assign core_clock_input = ctrl_b_r[0] ? plain_divider_output :
                            pll_divider_output; // RULE15

  // ****************************************
  // Read-back
  // ****************************************
  always @* begin
    reg_a_view = ctrl_a_r;
    reg_a_view[`DATA_IN_BIT] = spi_mode & is_input(ctrl_a_r[7:6]) &
                               data_in_s; // RULE3
    reg_a_view[`CLK_IN_BIT] = spi_mode & is_input(ctrl_a_r[3:2]) &
                              clk_in_s; // RULE6
    reg_b_view = {addr0_r, addr1_r, ctrl_b_r};
    reg_b_view[`MULTIFUNCTION_PIN_THREE_IN_BIT] = twowire_mode & ctrl_b_r[5] & multifunction_pin_three_s; // RULE12
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `BUS_PIN_GPIO_CONTROL_ADDR: rdata_nxt = reg_a_view;
        `MFP_CLOCK_SELECT_ADDR: rdata_nxt = reg_b_view;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule

/* File: verilog/gpio_reuse_defs.vh */
// Constants for the control-pin reuse register block.
// Assumes inclusion by bare name from the design files.
`ifndef GPIO_REUSE_DEFS_VH
`define GPIO_REUSE_DEFS_VH

`define BUS_PIN_GPIO_CONTROL_ADDR 7'h64
`define MFP_CLOCK_SELECT_ADDR 7'h65
`define ADDR_WIDTH 7
`define REG_RESET 8'h00

`define FN_NOT_GPIO 2'b00
`define FN_GP_INPUT 2'b01
`define FN_GP_OUTPUT 2'b10

`define DATA_FN_HI 7
`define DATA_FN_LO 6
`define DATA_OUT_BIT 5
`define DATA_IN_BIT 4
`define CLK_FN_HI 3
`define CLK_FN_LO 2
`define CLK_OUT_BIT 1
`define CLK_IN_BIT 0

`define ADDR0_BIT 7
`define ADDR1_BIT 6
`define MULTIFUNCTION_PIN_THREE_GPI_EN_BIT 5
`define MULTIFUNCTION_PIN_THREE_SDI_EN_BIT 4
`define MULTIFUNCTION_PIN_THREE_IN_BIT 3
`define MULTIFUNCTION_PIN_TWO_GPO_EN_BIT 2
`define MULTIFUNCTION_PIN_TWO_OUT_BIT 1
`define CLK_SRC_BIT 0

`endif

/* File: verilog/level_sync.v */
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes one clock; inputs come from pins outside its domain.
`timescale 1ns/10ps
module level_sync #(
  parameter WIDTH = 4
) (
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  // ****************************************
  // Synchroniser stages
  // ****************************************
  // Stages keep tracking pins during reset so straps are settled
  // at release; rst is kept only for a uniform port list
  always @(posedge core_clk) begin
    stage1_r <= async_in;
    stage2_r <= stage1_r;
  end

  assign sync_out = stage2_r;
endmodule

/* File: testbench/gpio_reuse_assertions.sv */
// Checker for the control-pin reuse registers.
// Assumes binding to the top module, all ports on core_clk.
`timescale 1ns/10ps
module gpio_reuse_chk (
  input wire core_clk,
  input wire rst,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire spi_select,
  input wire data_line_out,
  input wire data_line_oe_n,
  input wire clock_line_out,
  input wire clock_line_oe_n,
  input wire multifunction_pin_three_in,
  input wire gp_input_enable,
  input wire audio_serial_data_in_enable,
  input wire audio_serial_data_in,
  input wire multifunction_pin_two_out,
  input wire multifunction_pin_two_oe_n,
  input wire pll_divider_output,
  input wire plain_divider_output,
  input wire core_clock_input,
  input wire core_clock_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  open_drain_a: assert property (!data_line_out && !clock_line_out)
    else $error("bus pin driven high");
  clk_mux_a: assert property (core_clock_input == (core_clock_select ?
    plain_divider_output : pll_divider_output)) else $error("clock mux");
  pin_two_wr_a: assert property (reg_wr && reg_addr == 7'h65 |=>
    {multifunction_pin_two_out, core_clock_select} == $past(reg_wdata[1:0]))
    else $error("pin two or clock select");
  spi_gate_a: assert property (!data_line_oe_n || !clock_line_oe_n
    |-> $past(spi_select, 2)) else $error("bus pin used outside spi");
  two_wire_a: assert property (!multifunction_pin_two_oe_n ||
    gp_input_enable |-> !$past(spi_select, 2)) else $error("pin in spi");
  audio_serial_data_in_path_a: assert property (audio_serial_data_in |->
    audio_serial_data_in_enable && $past(multifunction_pin_three_in, 2))
    else $error("serial data path");
  drive_low_a: assert property (reg_wr && reg_addr == 7'h64 &&
    reg_wdata[7:5] == 3'b100 && $past(spi_select) |=> !data_line_oe_n)
    else $error("data line not pulled");
  release_a: assert property (reg_wr && reg_addr == 7'h64 &&
    reg_wdata[1] |=> clock_line_oe_n) else $error("clock line pulled");
endmodule

bind control_pin_gpio_reuse gpio_reuse_chk u_chk (.*);

/* File: testbench/test_control_pin_gpio_reuse.sv */
// Bench for the control-pin reuse registers.
// Assumes the design and checker files are compiled first.
`timescale 1ns/10ps
module test_control_pin_gpio_reuse;
  logic core_clk = 0, rst = 1, wr_s = 0, rd_s = 0, spi = 0, rd_d = 0;
  logic dl = 1, cl = 1, p0 = 1, p1 = 0, p3 = 0, pd = 0, cd = 0;
  logic [6:0] addr = 0;
  logic [7:0] wd = 0, v;
  logic [7:0] q[$];
  wire [7:0] rdata;
  wire dlo, dlx, clo, clx, gpe, sde, sdi, m2o, m2x, cki, cks;
  integer seed = 74, n_fail = 0, n_tests = 0, i, f, b;
  control_pin_gpio_reuse dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(rdata), .spi_select(spi), .data_line_in(dl & dlx),
    .data_line_out(dlo), .data_line_oe_n(dlx), .clock_line_in(cl & clx),
    .clock_line_out(clo), .clock_line_oe_n(clx),
    .multifunction_pin_zero_in(p0), .multifunction_pin_one_in(p1),
    .multifunction_pin_three_in(p3), .gp_input_enable(gpe),
    .audio_serial_data_in_enable(sde), .audio_serial_data_in(sdi),
    .multifunction_pin_two_out(m2o), .multifunction_pin_two_oe_n(m2x),
    .pll_divider_output(pd), .plain_divider_output(cd),
    .core_clock_input(cki), .core_clock_select(cks));
  always #2 core_clk = ~core_clk;
  task chk(input logic [7:0] g, input logic [7:0] x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %0t %h %h", $time, g, x);
    end
  endtask
  // Read results are compared against the oldest queued note
  always @(posedge core_clk) begin
    {pd, cd} <= $random(seed);
    rd_d <= rd_s;
    if (rd_d) chk(rdata, q.pop_front());
  end
  task w(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wd <= d;
    wr_s <= 1;
    @(posedge core_clk);
    wr_s <= 0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] x);
    @(posedge core_clk);
    addr <= a;
    rd_s <= 1;
    q.push_back(x);
    @(posedge core_clk);
    rd_s <= 0;
  endtask
  task report_and_stop;
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 0;
    w(4);
    {p0, p1} <= 2'b01;
    rd(7'h65, 8'h40);
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : $random(seed);
      p3 <= v[6];
      wr(7'h65, v);
      w(3);
      chk({gpe, sde, sdi, m2x, m2o, cks}, {v[5], v[4], v[4] & v[6],
        !v[2], v[1], v[0]});
      rd(7'h65, 8'h40 | v & 8'h37 | {v[5] & v[6], 3'b000});
    end
    spi <= 1;
    wr(7'h65, 8'h25);
    w(3);
    chk({gpe, m2x, cks}, 3'b011);
    for (i = 0; i < 6; i++) begin
      f = i % 3;
      b = 1 - i / 3;
      v = {f[1:0], b[0], 1'b0, f[1:0], b[0], 1'b0};
      {dl, cl} <= $random(seed);
      wr(7'h64, v);
      w(3);
      chk({dlx, clx, dlo, clo}, {{2{!(f == 2 && b == 0)}}, 2'b00});
      rd(7'h64, v | {3'b000, f == 1 & dl, 3'b000, f == 1 & cl});
    end
    chk({dlx, clx}, 2'b00);
    spi <= 0;
    w(3);
    chk({dlx, clx, gpe, m2x}, 4'b1110);
    rd(7'h66, 8'h00);
    w(3);
    report_and_stop;
  end
endmodule
